// ===== src/smc_regs.vh
`ifndef SMC_REGS_VH
`define SMC_REGS_VH
// register byte offsets: per bank a config word and a timing word
`define SMC_BANK_STRIDE 8'h08
`define SMC_CFG_OFS 1'b0
`define SMC_TIM_OFS 1'b1
`define SMC_STAT_ADDR 8'h40
// config word fields
`define SMC_CFG_WIDTH 1:0
`define SMC_CFG_CSPOL 2
`define SMC_CFG_RDLANE 3
`define SMC_CFG_WPROT 4
`define SMC_CFG_BURST 5
`define SMC_CFG_PAGE 6
`define SMC_CFG_IDLE 11:8
// timing word fields
`define SMC_TIM_RDW 4:0
`define SMC_TIM_WRW 12:8
`define SMC_TIM_BFIRST 20:16
`define SMC_TIM_BNEXT 28:24
// status word fields
`define SMC_STAT_BUSY 0
`define SMC_STAT_BANK 3:1
`define SMC_STAT_WPREJ 4
// width encodings
`define SMC_W8 2'h0
`define SMC_W16 2'h1
`define SMC_W32 2'h2
// reset values
`define SMC_CFG_RST 32'h00000F02
`define SMC_TIM_RST 32'h1F1F1F1F
// external base address pattern
`define SMC_EXT_BASE 3'h2
// extra strobe cycles: pin flop, three synchroniser flops, filter flop, capture
`define SMC_RD_LAT 6'h06
`endif

// ===== src/smc_top.v
// Overview of operation
// - address bits 28..26 pick bank 0..7.
// - only addresses with bits 31..29 equal 010 go to the external bus.
// - address bits 25..24 are ignored, so they alias within the bank.
// - external address bus comes from system address bits 23..0, plus the beat byte offset on 8 and 16 bit banks.
// - one select output per bank; only the addressed bank is asserted.
// - each bank select polarity is programmable high or low active.
// - each bank runs 8, 16 or 32 bit cycles as configured.
// - turnaround idle count per bank, one to sixteen cycles.
// - read then write to same bank inserts the turnaround idle cycles.
// - separate read and write wait counts, up to thirty-one each.
// - burst banks use a first-read wait and a following-read wait.
// - page-mode reads issue next in-page addresses without the initial wait.
// - burst reads run on burst-enabled banks.
// - four byte lane selects; per-bank option to assert them on reads.
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"
module smc_top (
	// clock and reset
	input wire clk_i,
	input wire nrst_i,
	// register port
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	// system access port
	input wire req_i,
	input wire we_i,
	input wire [31:0] addr_i,
	input wire [31:0] wdata_i,
	input wire [3:0] be_i,
	output reg busy_o,
	output reg ack_o,
	output reg err_o,
	output reg [31:0] rdata_o,
	// external memory pins
	output reg [7:0] bank_select_out_o,
	output reg [3:0] byte_lane_select_out_o,
	output reg write_strobe_n_o,
	output reg output_enable_n_o,
	output reg [23:0] ext_address_bus_o,
	input wire [31:0] ext_data_bus_i,
	output reg [31:0] ext_data_bus_o,
	output reg ext_data_bus_oe_o
);
	localparam ST_IDLE = 2'h0;
	localparam ST_TURN = 2'h1;
	localparam ST_STRB = 2'h2;
	localparam ST_HOLD = 2'h3;

	// byte offset of a beat within the word
	function [23:0] beat_off;
		input [1:0] w;
		input [1:0] b;
		begin
			case (w)
				`SMC_W8: beat_off = {22'h000000, b};
				`SMC_W16: beat_off = {21'h000000, b, 1'b0};
				default: beat_off = 24'h000000;
			endcase
		end
	endfunction

	// last beat index for a width
	function [1:0] last_beat;
		input [1:0] w;
		begin
			case (w)
				`SMC_W8: last_beat = 2'h3;
				`SMC_W16: last_beat = 2'h1;
				default: last_beat = 2'h0;
			endcase
		end
	endfunction

	// strobe length minus one for a beat
	function [5:0] beat_wait;
		input we;
		input [1:0] b;
		input [31:0] cfg;
		input [31:0] tim;
		reg [4:0] w;
		begin
			w = tim[`SMC_TIM_RDW];
			if (we)
				w = tim[`SMC_TIM_WRW];
			else if (b == 2'h0 && cfg[`SMC_CFG_BURST])
				w = tim[`SMC_TIM_BFIRST];
			else if (b != 2'h0 && (cfg[`SMC_CFG_BURST] || cfg[`SMC_CFG_PAGE]))
				w = tim[`SMC_TIM_BNEXT];
			beat_wait = we ? {1'b0, w} : ({1'b0, w} + `SMC_RD_LAT);
		end
	endfunction

	reg [31:0] cfg_reg [0:7];
	reg [31:0] tim_reg [0:7];
	reg wprej_reg;
	reg [1:0] state_reg;
	reg [5:0] cnt_reg;
	reg [1:0] beat_reg;
	reg acc_we_reg;
	reg [23:0] acc_addr_reg;
	reg [2:0] acc_bank_reg;
	reg [3:0] acc_be_reg;
	reg [31:0] acc_wdata_reg;
	reg [31:0] acc_cfg_reg;
	reg [31:0] acc_tim_reg;
	reg [31:0] rbuf_reg;
	reg last_rd_reg;
	reg [2:0] last_bank_reg;
	reg [31:0] d_s1_reg;
	reg [31:0] d_s2_reg;
	reg [31:0] d_s3_reg;
	reg [31:0] d_filt_reg;
	integer i;
	integer j;

	wire [2:0] req_bank = addr_i[28:26];
	wire req_ext = (addr_i[31:29] == `SMC_EXT_BASE);
	wire [31:0] req_cfg = cfg_reg[req_bank];
	wire [31:0] req_tim = tim_reg[req_bank];
	wire [1:0] acc_w = acc_cfg_reg[`SMC_CFG_WIDTH];
	wire reg_hit_bank = (reg_addr_i[7:6] == 2'h0) && (reg_addr_i[1:0] == 2'h0);
	wire [2:0] reg_bank = reg_addr_i[5:3];
	wire wprej_set = req_i && state_reg == ST_IDLE && req_ext && we_i && req_cfg[`SMC_CFG_WPROT];

	// data pins pass three flops; a bit changes once stages two and three agree
	always @(posedge clk_i) begin
		d_s1_reg <= ext_data_bus_i;
		d_s2_reg <= d_s1_reg;
		d_s3_reg <= d_s2_reg;
		d_filt_reg <= (~(d_s2_reg ^ d_s3_reg) & d_s3_reg) | ((d_s2_reg ^ d_s3_reg) & d_filt_reg);
		if (!nrst_i)
			d_filt_reg <= 32'h00000000;
	end

	// register file writes; the protect-reject set wins over the clear
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			for (i = 0; i < 8; i = i + 1) begin
				cfg_reg[i] <= `SMC_CFG_RST;
				tim_reg[i] <= `SMC_TIM_RST;
			end
			wprej_reg <= 1'b0;
		end else begin
			if (reg_wr_i && reg_hit_bank) begin
				if (reg_addr_i[2] == `SMC_TIM_OFS)
					tim_reg[reg_bank] <= reg_wdata_i;
				else
					cfg_reg[reg_bank] <= reg_wdata_i;
			end
			if (wprej_set)
				wprej_reg <= 1'b1;
			else if (reg_wr_i && reg_addr_i == `SMC_STAT_ADDR && reg_wdata_i[`SMC_STAT_WPREJ])
				wprej_reg <= 1'b0;
		end
	end

	// register reads answer one cycle later; unmapped reads return zero
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			if (reg_hit_bank)
				reg_rdata_o <= reg_addr_i[2] ? tim_reg[reg_bank] : cfg_reg[reg_bank];
			else if (reg_addr_i == `SMC_STAT_ADDR)
				reg_rdata_o <= {27'h0000000, wprej_reg, last_bank_reg, busy_o};
			else
				reg_rdata_o <= 32'h00000000;
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

	// access sequencer; config is latched at accept so mid-access writes are safe for every field but select polarity, which the pins read live
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 6'h00;
			beat_reg <= 2'h0;
			acc_we_reg <= 1'b0;
			acc_addr_reg <= 24'h000000;
			acc_bank_reg <= 3'h0;
			acc_be_reg <= 4'h0;
			acc_wdata_reg <= 32'h00000000;
			acc_cfg_reg <= 32'h00000000;
			acc_tim_reg <= 32'h00000000;
			rbuf_reg <= 32'h00000000;
			last_rd_reg <= 1'b0;
			last_bank_reg <= 3'h0;
			ack_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= 32'h00000000;
			busy_o <= 1'b0;
		end else begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (req_i) begin
						if (!req_ext || (we_i && req_cfg[`SMC_CFG_WPROT])) begin
							ack_o <= 1'b1;
							err_o <= 1'b1;
						end else begin
							acc_we_reg <= we_i;
							acc_addr_reg <= addr_i[23:0];
							acc_bank_reg <= req_bank;
							acc_be_reg <= be_i;
							acc_wdata_reg <= wdata_i;
							acc_cfg_reg <= req_cfg;
							acc_tim_reg <= req_tim;
							beat_reg <= 2'h0;
							rbuf_reg <= 32'h00000000;
							busy_o <= 1'b1;
							if (we_i && last_rd_reg && last_bank_reg == req_bank) begin
								state_reg <= ST_TURN;
								cnt_reg <= {2'h0, req_cfg[`SMC_CFG_IDLE]};
							end else begin
								state_reg <= ST_STRB;
								cnt_reg <= beat_wait(we_i, 2'h0, req_cfg, req_tim);
							end
						end
					end
				end
				ST_TURN: begin
					if (cnt_reg == 6'h00) begin
						state_reg <= ST_STRB;
						cnt_reg <= beat_wait(acc_we_reg, 2'h0, acc_cfg_reg, acc_tim_reg);
					end else begin
						cnt_reg <= cnt_reg - 6'h01;
					end
				end
				ST_STRB: begin
					if (cnt_reg == 6'h00) begin
						state_reg <= ST_HOLD;
						if (!acc_we_reg) begin
							// narrow banks return data on the low lanes
							case (acc_w)
								`SMC_W8:
									rbuf_reg <= rbuf_reg | ({24'h000000, d_filt_reg[7:0]} << {beat_reg, 3'h0});
								`SMC_W16:
									rbuf_reg <= rbuf_reg | ({16'h0000, d_filt_reg[15:0]} << {beat_reg[0], 4'h0});
								default:
									rbuf_reg <= d_filt_reg;
							endcase
						end
					end else begin
						cnt_reg <= cnt_reg - 6'h01;
					end
				end
				ST_HOLD: begin
					if (beat_reg == last_beat(acc_w)) begin
						state_reg <= ST_IDLE;
						ack_o <= 1'b1;
						rdata_o <= rbuf_reg;
						busy_o <= 1'b0;
						last_rd_reg <= ~acc_we_reg;
						last_bank_reg <= acc_bank_reg;
					end else begin
						state_reg <= ST_STRB;
						beat_reg <= beat_reg + 2'h1;
						cnt_reg <= beat_wait(acc_we_reg, beat_reg + 2'h1, acc_cfg_reg, acc_tim_reg);
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// pins follow the sequencer one cycle later, every pin from a flop
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			for (j = 0; j < 8; j = j + 1)
				bank_select_out_o[j] <= ~cfg_reg[j][`SMC_CFG_CSPOL];
			byte_lane_select_out_o <= 4'h0;
			write_strobe_n_o <= 1'b1;
			output_enable_n_o <= 1'b1;
			ext_address_bus_o <= 24'h000000;
			ext_data_bus_o <= 32'h00000000;
			ext_data_bus_oe_o <= 1'b0;
		end else begin
			// idle level of each select tracks its polarity setting
			for (j = 0; j < 8; j = j + 1)
				bank_select_out_o[j] <= cfg_reg[j][`SMC_CFG_CSPOL] ^
					~(state_reg[1] && acc_bank_reg == j[2:0]);
			write_strobe_n_o <= ~(state_reg == ST_STRB && acc_we_reg);
			output_enable_n_o <= ~(state_reg == ST_STRB && !acc_we_reg);
			ext_address_bus_o <= acc_addr_reg + beat_off(acc_w, beat_reg);
			ext_data_bus_oe_o <= state_reg[1] && acc_we_reg;
			if (!state_reg[1] || !(acc_we_reg || acc_cfg_reg[`SMC_CFG_RDLANE]))
				byte_lane_select_out_o <= 4'h0;
			else case (acc_w)
				`SMC_W8: byte_lane_select_out_o <= {3'h0, acc_be_reg[beat_reg]};
				`SMC_W16: byte_lane_select_out_o <= {2'h0, acc_be_reg[{beat_reg[0], 1'b1}],
					acc_be_reg[{beat_reg[0], 1'b0}]};
				default: byte_lane_select_out_o <= acc_be_reg;
			endcase
			case (acc_w)
				`SMC_W8: ext_data_bus_o <= {24'h000000, acc_wdata_reg[{beat_reg, 3'h0} +: 8]};
				`SMC_W16: ext_data_bus_o <= {16'h0000, acc_wdata_reg[{beat_reg[0], 4'h0} +: 16]};
				default: ext_data_bus_o <= acc_wdata_reg;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== bench/smc_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smc_top_checker (
	// watched ports
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [31:0] addr_i,
	input wire logic busy_o,
	input wire logic ack_o,
	input wire logic err_o,
	input wire logic [7:0] bank_select_out_o,
	input wire logic write_strobe_n_o,
	input wire logic output_enable_n_o,
	input wire logic [23:0] ext_address_bus_o,
	input wire logic ext_data_bus_oe_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
// select pattern while idle; a read strobe must move exactly one bank away from it
logic [7:0] idle_sel;
always_ff @(posedge clk_i)
	if (!nrst_i)
		idle_sel <= 8'hFF;
	else if (!busy_o && !ack_o)
		idle_sel <= bank_select_out_o;
// accepted external read, refused foreign request
sequence s_rd_go;
	req_i && !busy_o && !we_i && addr_i[31:29] == 3'h2;
endsequence
sequence s_refuse;
	req_i && !busy_o && addr_i[31:29] != 3'h2;
endsequence
a_strobes_exclusive: assert property (write_strobe_n_o || output_enable_n_o)
	else $error("write and read strobe low together");
a_write_drives_bus: assert property (!write_strobe_n_o |-> ext_data_bus_oe_o)
	else $error("write strobe without data drive");
a_single_bank: assert property (!output_enable_n_o |-> !ext_data_bus_oe_o &&
	$onehot(bank_select_out_o ^ idle_sel))
	else $error("read without single bank select");
a_idle_quiet: assert property (!busy_o |-> write_strobe_n_o && output_enable_n_o)
	else $error("strobe while sequencer idle");
a_refuse_fast: assert property (s_refuse |=> ack_o && err_o)
	else $error("foreign address not refused next cycle");
a_accept_busy: assert property (s_rd_go |=> busy_o && !ack_o)
	else $error("external read not started");
a_read_address: assert property (s_rd_go |-> ##2 !output_enable_n_o &&
	ext_address_bus_o == $past(addr_i[23:0], 2))
	else $error("read address not taken from system address");
a_bank_pick: assert property (s_rd_go |-> ##2
	(bank_select_out_o ^ $past(bank_select_out_o)) == (8'h01 << $past(addr_i[28:26], 2)))
	else $error("wrong bank select moved");
a_ack_bound: assert property ($rose(busy_o) |-> ##[1:700] ack_o)
	else $error("access never finished");
a_err_with_ack: assert property (err_o |-> ack_o)
	else $error("refusal without completion");
endmodule
bind smc_top smc_top_checker smc_top_checker_inst (.clk_i(clk_i), .nrst_i(nrst_i),
	.req_i(req_i), .we_i(we_i), .addr_i(addr_i), .busy_o(busy_o), .ack_o(ack_o),
	.err_o(err_o), .bank_select_out_o(bank_select_out_o),
	.write_strobe_n_o(write_strobe_n_o), .output_enable_n_o(output_enable_n_o),
	.ext_address_bus_o(ext_address_bus_o), .ext_data_bus_oe_o(ext_data_bus_oe_o));
`default_nettype wire

// ===== bench/smc_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module smc_sram_model (
	// memory pins
	input wire logic clk_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [3:0] lanes_i,
	input wire logic [23:0] addr_i,
	input wire logic [31:0] data_i,
	// access time in cycles
	input wire logic [5:0] lat_i,
	output logic [31:0] data_o
);
	logic [7:0] mem [0:255];
	logic [31:0] last;
	logic [23:0] pa;
	int cnt;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
		last = 32'h0;
		cnt = 0;
	end
	// byte memory: lane k lands at address plus k, so any bus width fits
	always @(posedge clk_i) begin
		if (!we_n_i)
			for (int k = 0; k < 4; k++)
				if (lanes_i[k]) mem[addr_i[7:0] + 8'(k)] <= data_i[8*k +: 8];
		cnt <= (!oe_n_i && addr_i == pa) ? cnt + 1 : 0;
		pa <= addr_i;
		last <= data_o;
	end
	// slow device: garbage until access time passes, inverted when released
	always_comb
		data_o = (!oe_n_i && cnt >= lat_i) ? {mem[addr_i[7:0] + 8'h03],
			mem[addr_i[7:0] + 8'h02], mem[addr_i[7:0] + 8'h01], mem[addr_i[7:0]]} : ~last;
endmodule
`default_nettype wire

// ===== bench/smc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
	$display("Error t=%0t got %h exp %h", $time, a, b); bad_count++; end end
module smc_top_bench;
	logic clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, req_i = 0, we_i = 0, e;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, addr_i = 32'h0, wdata_i = 32'h0, got;
	logic [3:0] be_i = 4'hF;
	logic [3:0] rd_lanes;
	logic [5:0] lat_sel = 6'h00;
	wire [31:0] reg_rdata_o, rdata_o, ext_data_bus_o, pdata, bus;
	wire [23:0] ext_address_bus_o;
	wire [7:0] bank_select_out_o;
	wire [3:0] byte_lane_select_out_o;
	wire busy_o, ack_o, err_o, write_strobe_n_o, output_enable_n_o, ext_data_bus_oe_o;
	int bad_count = 0, n_tests = 0, lat;
	always #5 clk_i = ~clk_i;
	// lanes seen under the read strobe, cleared by each new request
	always @(posedge clk_i)
		rd_lanes <= (req_i ? 4'h0 : rd_lanes) | (output_enable_n_o ? 4'h0 : byte_lane_select_out_o);
	// shared data wire: controller wins while it drives
	assign bus = ext_data_bus_oe_o ? ext_data_bus_o : pdata;
	smc_top smc_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .req_i(req_i), .we_i(we_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .be_i(be_i), .busy_o(busy_o), .ack_o(ack_o), .err_o(err_o),
		.rdata_o(rdata_o), .bank_select_out_o(bank_select_out_o),
		.byte_lane_select_out_o(byte_lane_select_out_o), .write_strobe_n_o(write_strobe_n_o),
		.output_enable_n_o(output_enable_n_o), .ext_address_bus_o(ext_address_bus_o),
		.ext_data_bus_i(bus), .ext_data_bus_o(ext_data_bus_o),
		.ext_data_bus_oe_o(ext_data_bus_oe_o));
	smc_sram_model smc_sram_model_inst (.clk_i(clk_i), .oe_n_i(output_enable_n_o),
		.we_n_i(write_strobe_n_o), .lanes_i(byte_lane_select_out_o),
		.addr_i(ext_address_bus_o), .data_i(bus), .lat_i(lat_sel), .data_o(pdata));
	task report_and_stop;
		$display("checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// register port: one-cycle strobes, read data in the following cycle
	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i); reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
		@(posedge clk_i); reg_wr_i <= 1'b0;
	endtask
	task reg_rd(input logic [7:0] a);
		@(posedge clk_i); reg_addr_i <= a; reg_rd_i <= 1'b1;
		@(posedge clk_i); reg_rd_i <= 1'b0;
		@(posedge clk_i); got = reg_rdata_o;
	endtask
	// one access; lat counts cycles from accept to the ack cycle
	task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i); req_i <= 1'b1; we_i <= w; addr_i <= a; wdata_i <= d;
		@(posedge clk_i); req_i <= 1'b0; lat = 0;
		while (ack_o !== 1'b1 && lat < 2000) begin @(posedge clk_i); lat++; end
		if (lat >= 2000) begin bad_count++; report_and_stop; end
		got = rdata_o;
		e = err_o;
	endtask
	task t_reset;
		reg_rd(8'h00); `CHK(got, `SMC_CFG_RST)
		reg_rd(8'h3C); `CHK(got, `SMC_TIM_RST)
		reg_rd(8'h7C); `CHK(got, 32'h0)
		`CHK({bank_select_out_o, write_strobe_n_o, output_enable_n_o}, 10'h3FF)
	endtask
	task t_banks;
		for (int b = 0; b < 8; b++) begin
			acc(1'b0, 32'h40000020 | (b << 26), 32'h0); `CHK(lat, 40)
			reg_rd(`SMC_STAT_ADDR); `CHK(got[3:1], 3'(b))
		end
		acc(1'b1, 32'h40000020, 32'h0); `CHK(lat, 34)
	endtask
	task t_turn;
		reg_wr(8'h18, 32'h00000306); reg_wr(8'h1C, 32'h0);
		repeat (2) @(posedge clk_i); `CHK(bank_select_out_o, 8'hF7)
		acc(1'b1, 32'h4D000010, 32'hA1B2C3D4); `CHK(lat, 3)
		acc(1'b0, 32'h4C000010, 32'h0); `CHK(got, 32'hA1B2C3D4)
		`CHK(rd_lanes, 4'h0)
		acc(1'b1, 32'h4C000010, 32'h5A5A0000); `CHK(lat, 7)
		acc(1'b1, 32'h4C000010, 32'h5A5A0000); `CHK(lat, 3)
	endtask
	task t_narrow;
		reg_wr(8'h28, 32'h0); reg_wr(8'h2C, 32'h01010002); lat_sel <= 6'h02;
		acc(1'b1, 32'h54000040, 32'h11223344); `CHK(lat, 9)
		acc(1'b0, 32'h54000040, 32'h0); `CHK({got, 8'(lat)}, 40'h1122334429)
		reg_wr(8'h28, 32'h40); lat_sel <= 6'h01;
		acc(1'b0, 32'h54000040, 32'h0); `CHK({got, 8'(lat)}, 40'h1122334426)
		reg_wr(8'h28, 32'h20);
		acc(1'b0, 32'h54000040, 32'h0); `CHK({got, 8'(lat)}, 40'h1122334425)
	endtask
	task t_refuse;
		reg_wr(8'h28, 32'h18);
		acc(1'b1, 32'h54000040, 32'hFFFFFFFF); `CHK({e, 8'(lat)}, 9'h101)
		reg_rd(`SMC_STAT_ADDR); `CHK(got[4], 1'b1)
		reg_wr(`SMC_STAT_ADDR, 32'h10); reg_rd(`SMC_STAT_ADDR); `CHK(got[4], 1'b0)
		acc(1'b0, 32'h54000040, 32'h0); `CHK(got, 32'h11223344)
		`CHK(rd_lanes, 4'h1)
		acc(1'b0, 32'h20000000, 32'h0); `CHK({e, 8'(lat)}, 9'h101)
	endtask
	// reset held twenty cycles, then every scenario in turn
	initial begin
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_reset;
		t_banks;
		t_turn;
		t_narrow;
		t_refuse;
		report_and_stop;
	end
endmodule
`default_nettype wire
